// [ck_edge.sv]
`default_nettype none

module ck_edge (
    input  wire logic core_clk, // System clock
    input  wire logic srst,     // Synchronous reset
    input  wire logic ce,       // Clock enable
    input  wire logic ckLevel,  // Synchronised serial clock
    output logic      rise,     // Rising edge pulse
    output logic      fall      // Falling edge pulse
);
    logic prev;
    logic next_prev;

    // Previous level of the serial clock
    always_comb begin
        next_prev = ckLevel;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev <= 1'b0;
        end else if (ce) begin
            prev <= next_prev;
        end
    end

    // Edges only count while the state may advance
    assign rise = ce & ckLevel & ~prev;
    assign fall = ce & ~ckLevel & prev;
endmodule

`default_nettype wire

// [pin_sync.sv]
`default_nettype none

module pin_sync #(
    parameter int W = 2
) (
    input  wire logic         core_clk, // System clock
    input  wire logic         srst,     // Synchronous reset
    input  wire logic         ce,       // Clock enable
    input  wire logic [W-1:0] d,        // Asynchronous inputs
    output logic      [W-1:0] q         // Synchronised outputs
);
    logic [1:0][W-1:0] stages;
    logic [1:0][W-1:0] next_stages;

    // Two-stage shift, only the second stage leaves
    always_comb begin
        next_stages = {stages[0], d};
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            stages <= '0;
        end else if (ce) begin
            stages <= next_stages;
        end
    end

    assign q = stages[1];
endmodule

`default_nettype wire

// [usart_sync_map.svh]
`ifndef USART_SYNC_MAP_SVH
`define USART_SYNC_MAP_SVH

// Register byte offsets on the bus
`define ADR_W          6
`define REG_CTRL       6'h00
`define REG_IEN        6'h04
`define REG_TXDATA     6'h08
`define REG_RXDATA     6'h0c
`define REG_STATUS     6'h10

// Control register fields
`define CTRL_W         11
`define CTRL_RESET     11'h000
`define CTRL_SYNC      0
`define CTRL_CLKSRC    1
`define CTRL_SINGLE_RECEIVE_ENABLE      2
`define CTRL_CONTINUOUS_RECEIVE_ENABLE      3
`define CTRL_PORTEN    4
`define CTRL_TRANSMIT_ENABLE      5
`define CTRL_TX9       6
`define CTRL_NINTH_BIT_TRANSMIT_DATA      7
`define CTRL_RX9       8
`define CTRL_ANACK     9
`define CTRL_ANADT     10
`define CTRL_HI_W      3

// Interrupt enable register fields
`define IEN_W          4
`define IEN_RESET      4'h0
`define IEN_TX         0
`define IEN_RX         1
`define IEN_PERIPH     2
`define IEN_GLOBAL     3

// Status register fields
`define ST_W           4
`define ST_TRANSMIT_BUFFER_EMPTY_FLAG        0
`define ST_RECEIVE_COMPLETE_FLAG        1
`define ST_OVERRUN     2
`define ST_TXIDLE      3

// Character and counter sizes
`define CHAR_W         9
`define CNT_W          4
`define BITS_EIGHT     4'h8
`define BITS_NINE      4'h9
`define CNT_ZERO       4'h0
`define CNT_ONE        4'h1

`endif

// [usart_sync_master_model.sv]
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Far-side synchronous master: makes the serial clock, drives or samples data
module usart_sync_master_model (
    output logic      ck,     // Serial clock, low while idle
    output logic      dt,     // Data towards the slave
    input  wire logic dtLine  // Resolved data line
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock stands still outside frames
    initial begin
        ck = 1'h0;
        dt = 1'h0;
    end

    // Send n bits LSB first; data moves on the rise, slave samples the fall
    task automatic sendWord(input logic [8:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            ck = 1'h1;
            dt = w[i];
            #32 ck = 1'h0;
            #32;
        end
        dt = ~dt; // Released line must not show a stale bit
    endtask

    // Clock n bits in, sampling the line just before each rise
    task automatic getWord(output logic [8:0] w, input int n);
        w = 9'h000;
        for (int i = 0; i < n; i++) begin
            #32 w[i] = dtLine;
            ck = 1'h1;
            #32 ck = 1'h0;
        end
    endtask
endmodule

`default_nettype wire

// [usart_sync_pkg.sv]
`default_nettype none
`include "usart_sync_map.svh"

package usart_sync_pkg;

    // Wishbone request from the master
    typedef struct packed {
        logic                cyc;
        logic                stb;
        logic                we;
        logic [3:0]          sel;
        logic [`ADR_W-1:0]   adr;
        logic [31:0]         dat;
    } wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic                ack;
        logic [31:0]         dat;
    } wb_rsp_t;

    // State of the serial port, apart from pin capture and edge detection
    typedef struct packed {
        logic                ack;
        logic [31:0]         rdData;
        logic [`CTRL_W-1:0]  ctrl;
        logic [`IEN_W-1:0]   ien;
        logic [`CHAR_W-1:0]  hold;
        logic                holdFull;
        logic [`CHAR_W-1:0]  transmit_shift_register;
        logic [`CNT_W-1:0]   txLeft;
        logic                dtOut;
        logic [`CHAR_W-1:0]  receive_shift_register;
        logic [`CNT_W-1:0]   rxCount;
        logic [`CHAR_W-1:0]  rcReg;
        logic                receive_complete_flag;
        logic                overrun;
        logic                txIrq;
        logic                rxIrq;
        logic                wake;
        logic                vector;
    } state_t;

endpackage

`default_nettype wire

// [usart_sync_slave.sv]
`default_nettype none

module usart_sync_slave
    import usart_sync_pkg::*;
(
    input  wire logic                    core_clk,  // System clock, 125 MHz
    input  wire logic                    srst,      // Synchronous reset
    input  wire logic                    ce,        // Clock enable
    input  wire usart_sync_pkg::wb_req_t wbIn,      // Bus request
    output usart_sync_pkg::wb_rsp_t      wbOut,     // Bus answer
    input  wire logic                    ckPinIn,   // Serial clock pin level
    output logic                         ckPinOut,  // Serial clock drive value
    output logic                         ckPinOe,   // Serial clock drive enable
    input  wire logic                    dtPinIn,   // Serial data pin level
    output logic                         dtPinOut,  // Serial data drive value
    output logic                         dtPinOe,   // Serial data drive enable
    input  wire logic                    cpuSleep,  // Core is asleep
    output logic                         txIrq,     // Transmit interrupt level
    output logic                         rxIrq,     // Receive interrupt level
    output logic                         wakeReq,   // Wake the core
    output logic                         vectorReq  // Wake goes to the vector
);
    import usart_sync_pkg::*;

    state_t            s;
    state_t            next_s;
    logic [1:0]        pinSync;
    logic              ckRise;
    logic              ckFall;
    logic              ckDig;
    logic              dtDig;
    logic              portOn;
    logic              txDir;
    logic              txGo;
    logic              rxGo;
    logic              busReq;
    logic              wrStrobe;
    logic              rdStrobe;
    logic              pop;
    logic [`CNT_W-1:0] txWidth;
    logic [`CNT_W-1:0] rxWidth;
    logic              rxLast;
    logic [`CHAR_W-1:0] rxShift;
    logic [`CHAR_W-1:0] rxWord;
    logic              transmit_buffer_empty_flag;

    ////////////////////////////////////////////////////////////////////////////
    // Pin capture

    // Both pins through two flops
    pin_sync #(
        .W (2)
    ) u_pins (
        .core_clk (core_clk),
        .srst     (srst),
        .ce       (ce),
        .d        ({dtPinIn, ckPinIn}),
        .q        (pinSync)
    );

    // Analog-selected pins read as idle low
    assign ckDig = pinSync[0] & ~s.ctrl[`CTRL_ANACK];
    assign dtDig = pinSync[1] & ~s.ctrl[`CTRL_ANADT];

    // Edges of the master's clock
    ck_edge u_edge (
        .core_clk (core_clk),
        .srst     (srst),
        .ce       (ce),
        .ckLevel  (ckDig),
        .rise     (ckRise),
        .fall     (ckFall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    // Synchronous clock slave, enabled
    assign portOn  = s.ctrl[`CTRL_PORTEN] & s.ctrl[`CTRL_SYNC]
                   & ~s.ctrl[`CTRL_CLKSRC];
    assign txDir   = ~s.ctrl[`CTRL_SINGLE_RECEIVE_ENABLE] & ~s.ctrl[`CTRL_CONTINUOUS_RECEIVE_ENABLE];
    assign txGo    = portOn & txDir & s.ctrl[`CTRL_TRANSMIT_ENABLE];
    assign rxGo    = portOn & s.ctrl[`CTRL_CONTINUOUS_RECEIVE_ENABLE];
    assign txWidth = s.ctrl[`CTRL_TX9] ? `BITS_NINE : `BITS_EIGHT;
    assign rxWidth = s.ctrl[`CTRL_RX9] ? `BITS_NINE : `BITS_EIGHT;
    assign transmit_buffer_empty_flag    = ~s.holdFull;

    // Receive shift, LSB first into the top
    assign rxShift = {dtDig, s.receive_shift_register[`CHAR_W-1:1]};
    assign rxWord  = s.ctrl[`CTRL_RX9] ? rxShift : {1'b0, rxShift[`CHAR_W-1:1]};
    assign rxLast  = (s.rxCount == rxWidth - `CNT_ONE);

    // Bus strobes, taken at the acknowledge edge
    assign busReq   = wbIn.cyc & wbIn.stb;
    assign wrStrobe = busReq & s.ack & wbIn.we;
    assign rdStrobe = busReq & s.ack & ~wbIn.we;
    assign pop      = rdStrobe & (wbIn.adr == `REG_RXDATA);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;

        // Bus slave: ack one cycle after request
        next_s.ack = busReq & ~s.ack;
        if (busReq & ~s.ack) begin
            case (wbIn.adr)
                `REG_CTRL:   next_s.rdData = {{(32-`CTRL_W){1'b0}}, s.ctrl};
                `REG_IEN:    next_s.rdData = {{(32-`IEN_W){1'b0}}, s.ien};
                `REG_RXDATA: next_s.rdData = {{(32-`CHAR_W){1'b0}}, s.rcReg};
                `REG_STATUS: next_s.rdData = {{(32-`ST_W){1'b0}},
                                              (s.txLeft == `CNT_ZERO), s.overrun,
                                              s.receive_complete_flag, transmit_buffer_empty_flag};
                default:     next_s.rdData = 32'h0000_0000;
            endcase
        end
        if (wrStrobe && wbIn.adr == `REG_CTRL) begin
            if (wbIn.sel[0]) begin
                next_s.ctrl[7:0] = wbIn.dat[7:0];
            end
            if (wbIn.sel[1]) begin
                next_s.ctrl[`CTRL_W-1:8] = wbIn.dat[`CTRL_W-1:8];
            end
        end
        if (wrStrobe && wbIn.adr == `REG_IEN && wbIn.sel[0]) begin
            next_s.ien = wbIn.dat[`IEN_W-1:0];
        end

        // Low byte written: fill the holding register
        if (wrStrobe && wbIn.adr == `REG_TXDATA && wbIn.sel[0] && !s.holdFull) begin
            next_s.hold     = {s.ctrl[`CTRL_NINTH_BIT_TRANSMIT_DATA], wbIn.dat[7:0]};
            next_s.holdFull = 1'b1;
        end

        // Transmit: load when idle, shift on master rising edges
        if (!txGo) begin
            next_s.txLeft = `CNT_ZERO;
        end else if (s.txLeft == `CNT_ZERO) begin
            if (s.holdFull) begin
                next_s.transmit_shift_register      = s.hold;
                next_s.dtOut    = s.hold[0];
                next_s.txLeft   = txWidth;
                next_s.holdFull = 1'b0;
            end
        end else if (ckRise) begin
            next_s.transmit_shift_register    = {1'b0, s.transmit_shift_register[`CHAR_W-1:1]};
            next_s.dtOut  = s.transmit_shift_register[1];
            next_s.txLeft = s.txLeft - `CNT_ONE;
        end

        // Receive: flag clear by read, set wins
        if (pop) begin
            next_s.receive_complete_flag = 1'b0;
        end
        if (!rxGo) begin
            next_s.rxCount = `CNT_ZERO;
        end else if (ckFall) begin
            next_s.receive_shift_register     = rxShift;
            next_s.rxCount = s.rxCount + `CNT_ONE;
            if (rxLast) begin
                next_s.rxCount = `CNT_ZERO;
                if (s.receive_complete_flag && !pop) begin
                    next_s.overrun = 1'b1;
                end else begin
                    next_s.rcReg = rxWord;
                    next_s.receive_complete_flag  = 1'b1;
                end
            end
        end
        if (!s.ctrl[`CTRL_CONTINUOUS_RECEIVE_ENABLE]) begin
            next_s.overrun = 1'b0;
        end

        // Port disabled clears the holding flag, counters, data output, receive flag and overrun
        if (!s.ctrl[`CTRL_PORTEN]) begin
            next_s.holdFull = 1'b0;
            next_s.txLeft   = `CNT_ZERO;
            next_s.dtOut    = 1'b0;
            next_s.rxCount  = `CNT_ZERO;
            next_s.receive_complete_flag     = 1'b0;
            next_s.overrun  = 1'b0;
        end

        // Interrupt, wake and vector levels
        next_s.txIrq  = transmit_buffer_empty_flag & s.ien[`IEN_TX] & s.ien[`IEN_PERIPH];
        next_s.rxIrq  = s.receive_complete_flag & s.ien[`IEN_RX];
        next_s.wake   = cpuSleep & (next_s.txIrq | next_s.rxIrq);
        next_s.vector = next_s.wake & s.ien[`IEN_GLOBAL];
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s      <= '0;
            s.ctrl <= `CTRL_RESET;
            s.ien  <= `IEN_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wbOut.ack = s.ack;
    assign wbOut.dat = s.rdData;
    assign ckPinOut  = 1'b0;
    assign ckPinOe   = 1'b0;
    assign dtPinOut  = s.dtOut;
    assign dtPinOe   = txGo;
    assign txIrq     = s.txIrq;
    assign rxIrq     = s.rxIrq;
    assign wakeReq   = s.wake;
    assign vectorReq = s.vector;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_tx_load;
        ce && txGo && s.txLeft == `CNT_ZERO && s.holdFull;
    endsequence

    sequence s_rx_last;
        ce && rxGo && ckFall && rxLast;
    endsequence

    property p_ck_slave;
        !ckPinOe && !ckPinOut;
    endproperty
    a_ck_slave: assert property (p_ck_slave) else $error("serial clock driven");

    property p_dt_dir;
        dtPinOe |-> (txDir && s.ctrl[`CTRL_TRANSMIT_ENABLE] && s.ctrl[`CTRL_PORTEN]
                     && s.ctrl[`CTRL_SYNC] && !s.ctrl[`CTRL_CLKSRC]);
    endproperty
    a_dt_dir: assert property (p_dt_dir) else $error("data driven outside transmit");

    property p_disable;
        (ce && !s.ctrl[`CTRL_PORTEN]) |=> (!s.receive_complete_flag && !s.overrun && s.txLeft == `CNT_ZERO
                                           && !s.holdFull);
    endproperty
    a_disable: assert property (p_disable) else $error("port not reset when disabled");

    property p_tx_load;
        s_tx_load |=> (s.txLeft == $past(txWidth) && !s.holdFull
                       && s.dtOut == $past(s.hold[0]));
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("holding word not loaded");

    property p_transmit_buffer_empty_flag_rise;
        (ce && s.holdFull && s.ctrl[`CTRL_PORTEN] && !(txGo && s.txLeft == `CNT_ZERO))
            |=> s.holdFull;
    endproperty
    a_transmit_buffer_empty_flag_rise: assert property (p_transmit_buffer_empty_flag_rise) else $error("empty flag set while busy");

    property p_shift;
        (ce && txGo && ckRise && s.txLeft > `CNT_ONE) |=> (s.dtOut == $past(s.transmit_shift_register[1])
                                                          && s.txLeft == $past(s.txLeft) - 1);
    endproperty
    a_shift: assert property (p_shift) else $error("transmit bit not advanced");

    property p_rx_done;
        (s_rx_last and !s.receive_complete_flag) |=> (s.receive_complete_flag && s.rcReg == $past(rxWord));
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("received word not stored");

    property p_overrun;
        (s_rx_last and (s.receive_complete_flag && !pop)) |=> s.overrun ##1 (!ce || s.overrun
                                                          || !s.ctrl[`CTRL_CONTINUOUS_RECEIVE_ENABLE]
                                                          || !s.ctrl[`CTRL_PORTEN]);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_overrun_clear;
        (ce && !s.ctrl[`CTRL_CONTINUOUS_RECEIVE_ENABLE]) |=> !s.overrun;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept");

    property p_wake_tx;
        (ce && cpuSleep && s.txIrq) |=> wakeReq;
    endproperty
    a_wake_tx: assert property (p_wake_tx) else $error("no wake on transmit");

    property p_vector_rx;
        (ce && cpuSleep && s.rxIrq && s.ien[`IEN_GLOBAL]) |=> vectorReq;
    endproperty
    a_vector_rx: assert property (p_vector_rx) else $error("no vector on receive");

    sequence s_tx_wake_ready;
        ce && cpuSleep && transmit_buffer_empty_flag && s.ien[`IEN_TX] && s.ien[`IEN_PERIPH];
    endsequence

    property p_vector_tx;
        (s_tx_wake_ready ##0 s.ien[`IEN_GLOBAL]) |=> (vectorReq && wakeReq && txIrq);
    endproperty
    a_vector_tx: assert property (p_vector_tx) else $error("no vector on transmit");

    property p_wake_rx;
        (ce && cpuSleep && s.receive_complete_flag && s.ien[`IEN_RX]) |=> (wakeReq && rxIrq);
    endproperty
    a_wake_rx: assert property (p_wake_rx) else $error("no wake on receive");

    property p_hold_keep;
        (ce && s.holdFull && s.txLeft != `CNT_ZERO && s.ctrl[`CTRL_PORTEN])
            |=> (s.holdFull && s.hold == $past(s.hold));
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("waiting word lost");

    property p_ninth_load;
        (ce && wrStrobe && wbIn.adr == `REG_TXDATA && wbIn.sel[0] && !s.holdFull
         && s.ctrl[`CTRL_PORTEN])
            |=> (s.holdFull && s.hold == {$past(s.ctrl[`CTRL_NINTH_BIT_TRANSMIT_DATA]), $past(wbIn.dat[7:0])});
    endproperty
    a_ninth_load: assert property (p_ninth_load) else $error("ninth bit not held");

    property p_rx_count;
        (ce && rxGo && ckFall && !rxLast) |=> (s.rxCount == $past(s.rxCount) + `CNT_ONE);
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("receive bit not counted");
endmodule

`default_nettype wire

// [usart_sync_slave_bench.sv]
`default_nettype none
`include "usart_sync_map.svh"

module usart_sync_slave_bench;
    import usart_sync_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic    core_clk;
    logic    srst;
    logic    ce;
    logic    cpuSleep;
    wb_req_t wbReq;
    wb_rsp_t wbRsp;
    logic    ckPinOut;
    logic    ckPinOe;
    logic    dtPinOut;
    logic    dtPinOe;
    logic    txIrq;
    logic    rxIrq;
    logic    wakeReq;
    logic    vectorReq;
    logic    mCk;
    logic    mDt;
    wire logic ckLine;
    wire logic dtLine;
    int      fails;
    int      nChecks;

    // Pin levels from the slave's enables, else the master's values
    assign ckLine = ckPinOe ? ckPinOut : mCk;
    assign dtLine = dtPinOe ? dtPinOut : mDt;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and far side
    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end

    usart_sync_slave uut (
        .core_clk(core_clk), .srst(srst), .ce(ce), .wbIn(wbReq), .wbOut(wbRsp),
        .ckPinIn(ckLine), .ckPinOut(ckPinOut), .ckPinOe(ckPinOe),
        .dtPinIn(dtLine), .dtPinOut(dtPinOut), .dtPinOe(dtPinOe),
        .cpuSleep(cpuSleep), .txIrq(txIrq), .rxIrq(rxIrq),
        .wakeReq(wakeReq), .vectorReq(vectorReq)
    );

    usart_sync_master_model master (.ck(mCk), .dt(mDt), .dtLine(dtLine));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic bus cycle, held until ack is sampled
    task automatic wbCycle(input logic we, input logic [5:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        wbReq <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'hf, adr: a, dat: d};
        @(posedge core_clk);
        while (wbRsp.ack !== 1'h1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) check(32'h0, 32'h1);
        q = wbRsp.dat;
        wbReq.cyc <= 1'h0;
        wbReq.stb <= 1'h0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        wbCycle(1'h1, a, d, q);
    endtask

    task automatic rdChk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wbCycle(1'h0, a, 32'h0, q);
        check(q & m, e);
    endtask

    task automatic waitWake;
        int n;
        n = 0;
        while (wakeReq !== 1'h1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic testReset;
        rdChk(`REG_CTRL, 32'hffffffff, 32'h0);
        rdChk(`REG_STATUS, 32'hffffffff, 32'h9);
        rdChk(6'h3c, 32'hffffffff, 32'h0);
        check(32'({ckPinOe, dtPinOe, wakeReq, vectorReq}), 32'h0);
    endtask

    // Word waits until the port is a transmitting slave
    task automatic testTxEnable;
        logic [31:0] cfg [3];
        logic [8:0]  w;
        cfg = '{32'h15, 32'h33, 32'h11};
        wr(`REG_CTRL, 32'h11);
        wr(`REG_TXDATA, 32'ha5);
        foreach (cfg[i]) begin
            wr(`REG_CTRL, cfg[i]);
            repeat (4) @(posedge core_clk);
            check(32'({ckPinOut, ckPinOe, dtPinOe}), 32'h0);
        end
        wr(`REG_CTRL, 32'h31);
        repeat (2) @(posedge core_clk);
        check(32'(dtPinOe), 32'h1);
        master.getWord(w, 8);
        check(32'(w), 32'ha5);
        wr(`REG_CTRL, 32'h21);
        repeat (2) @(posedge core_clk);
        check(32'(dtPinOe), 32'h0);
    endtask

    // Two nine-bit words, then sleep
    task automatic testSleepTx;
        logic [8:0] w;
        wr(`REG_CTRL, 32'hf1);
        wr(`REG_TXDATA, 32'h3c);
        wr(`REG_CTRL, 32'h71);
        wr(`REG_TXDATA, 32'hc3);
        rdChk(`REG_STATUS, 32'h1, 32'h0);
        wr(`REG_IEN, 32'hd);
        cpuSleep <= 1'h1;
        repeat (4) @(posedge core_clk);
        check(32'({txIrq, wakeReq}), 32'h0);
        master.getWord(w, 9);
        check(32'(w), 32'h13c);
        waitWake;
        check(32'({wakeReq, vectorReq, txIrq}), 32'h7);
        cpuSleep <= 1'h0;
        rdChk(`REG_STATUS, 32'h1, 32'h1);
        master.getWord(w, 9);
        check(32'(w), 32'h0c3);
        wr(`REG_IEN, 32'h0);
    endtask

    // Reception in sleep, wake, overrun and its clearing
    task automatic testRx;
        wr(`REG_CTRL, 32'h13d);
        repeat (2) @(posedge core_clk);
        check(32'(dtPinOe), 32'h0);
        wr(`REG_IEN, 32'h2);
        cpuSleep <= 1'h1;
        master.sendWord(9'h15a, 9);
        waitWake;
        check(32'({wakeReq, vectorReq, rxIrq}), 32'h5);
        cpuSleep <= 1'h0;
        rdChk(`REG_RXDATA, 32'h1ff, 32'h15a);
        rdChk(`REG_STATUS, 32'h6, 32'h0);
        wr(`REG_IEN, 32'ha);
        cpuSleep <= 1'h1;
        master.sendWord(9'h0a5, 9);
        waitWake;
        check(32'(vectorReq), 32'h1);
        cpuSleep <= 1'h0;
        master.sendWord(9'h15a, 9);
        repeat (8) @(posedge core_clk);
        rdChk(`REG_STATUS, 32'h6, 32'h6);
        rdChk(`REG_RXDATA, 32'h1ff, 32'h0a5);
        wr(`REG_CTRL, 32'h135);
        rdChk(`REG_STATUS, 32'h4, 32'h0);
    endtask

    // Analog clock pin and a frozen clock enable stop reception; an analog data pin receives zeros
    task automatic testPins;
        wr(`REG_CTRL, 32'h33d);
        master.sendWord(9'h1ff, 9);
        repeat (8) @(posedge core_clk);
        rdChk(`REG_STATUS, 32'h2, 32'h0);
        wr(`REG_CTRL, 32'h53d);
        master.sendWord(9'h1ff, 9);
        repeat (8) @(posedge core_clk);
        rdChk(`REG_RXDATA, 32'h1ff, 32'h000);
        wr(`REG_CTRL, 32'h13d);
        ce <= 1'h0;
        @(posedge core_clk);
        master.sendWord(9'h0f0, 9);
        @(posedge core_clk);
        ce <= 1'h1;
        repeat (8) @(posedge core_clk);
        rdChk(`REG_STATUS, 32'h2, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog
    task automatic printVerdict;
        if (fails == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        srst = 1'h1;
        cpuSleep = 1'h0;
        ce = 1'h1;
        wbReq = '0;
        fails = 0;
        nChecks = 0;
        repeat (8) @(posedge core_clk);
        srst <= 1'h0;
        testReset;
        testTxEnable;
        testSleepTx;
        testRx;
        testPins;
        printVerdict;
    end

    initial begin
        #100000;
        fails++;
        printVerdict;
    end
endmodule

`default_nettype wire
